// >>> inc/swfg_defines.svh
// constants for the switch-onto-fault guard
`ifndef SWFG_DEFINES_SVH
`define SWFG_DEFINES_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SWFG_CLK_NS 10
`define SWFG_TICK_NS 1000000
`define SWFG_REL_DEF_MS 21'h0003e8
`define SWFG_REL_MAX_MS 21'h1b7740

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SWFG_A_CTRL 8'h00
`define SWFG_A_STATUS 8'h04
`define SWFG_A_CNTCLR 8'h08
`define SWFG_A_REMAIN 8'h0c
`define SWFG_A_ELAPSED 8'h10
`define SWFG_A_CNT0 8'h20
`define SWFG_A_CNT3 8'h2c
`define SWFG_A_REL0 8'h40
`define SWFG_A_REL7 8'h5c
`define SWFG_A_RECSEL 8'h60
`define SWFG_A_RECINFO 8'h64
`define SWFG_A_RECTIME 8'h70
`define SWFG_A_RECID 8'h74
`define SWFG_A_RECREM 8'h78
`define SWFG_A_RECELA 8'h7c

// ----------------------------------------------------------------
// control field bit positions
// ----------------------------------------------------------------
`define SWFG_CTRL_FEN 0
`define SWFG_CTRL_FSEL_LO 1
`define SWFG_CTRL_FSEL_HI 2
`define SWFG_CTRL_ON 3
`define SWFG_CTRL_OFF 4

// ----------------------------------------------------------------
// event flag index and record id
// ----------------------------------------------------------------
`define SWFG_EV_INIT 0
`define SWFG_EV_BLOCK 1
`define SWFG_EV_ACT 2
`define SWFG_EV_TRIP 3
`define SWFG_RECID_ACT_ON 4'h4
`define SWFG_REC_DEPTH 12

`endif

// >>> inc/swfg_pkg.sv
// types for the switch-onto-fault guard
package swfg_pkg;

  typedef enum logic [4:0] {
    ST_NORMAL = 5'h01,
    ST_INIT = 5'h02,
    ST_ACTIVE = 5'h04,
    ST_TRIP = 5'h08,
    ST_BLOCKED = 5'h10
  } swfg_state_t;

  typedef enum logic [1:0] {
    FRC_NORMAL = 2'h0,
    FRC_BLOCKED = 2'h1,
    FRC_ACTIVE = 2'h2,
    FRC_TRIP = 2'h3
  } swfg_force_t;

endpackage

// >>> hw/swfg_record_mem.sv
// record store with registered read port
`timescale 1ns/1ps
`default_nettype none

module swfg_record_mem #(
  parameter int WIDTH = 81,
  parameter int DEPTH = 12,
  parameter int ADDR_W = 4
) (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd;
  } swfg_mem_t;

  swfg_mem_t s_q;
  swfg_mem_t s_d;

  always_comb begin
    s_d = s_q;
    if (wrEn && (int'(wrAddr) < DEPTH)) begin
      s_d.mem[wrAddr] = wrData;
    end
    s_d.rd = (int'(rdAddr) < DEPTH) ? s_q.mem[rdAddr] : '0;
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign rdData = s_q.rd;

endmodule

`default_nettype wire

// >>> hw/swfg_switch_onto_fault_guard.sv
// switch-onto-fault guard window with events, counters and record log
// Notes on behaviour
// - the window arms only on a rising edge of the arming input, never on a held level.
// - while the window runs, any active fault detector input raises the trip output at once.
// - an active block input keeps the window from starting, even on an arming edge.
// - the window lasts a programmable 0 to 1800 s interval, one second by default.
// - the interval comes from the selected setting group, also when it changes mid-window.
// - a forcing setting (normal, blocked, active, trip) applies only while forcing is enabled.
// - a readable condition shows normal, initiated, active, tripped or blocked.
// - time-stamped on and off events for the four conditions are gated by an on/off mask.
// - clearable counters count each initiated, blocked, active and trip occurrence once.
// - each activation stores time, event, group, remaining and elapsed time; twelve kept.
`timescale 1ns/1ps
`default_nettype none
`include "swfg_defines.svh"

module swfg_switch_onto_fault_guard #(
  parameter int NFAULT = 4,
  parameter int NGRP = 8,
  parameter int CNT_W = 16,
  parameter int TS_W = 32,
  parameter int TICK_CYCLES = `SWFG_TICK_NS / `SWFG_CLK_NS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic armingInput,
  input wire logic guardBlockInput,
  input wire logic [NFAULT-1:0] faultDetectorInput,
  input wire logic [2:0] settingGroupSelect,
  input wire logic [TS_W-1:0] timeNow,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic guardActiveOutput,
  output logic guardTripOutput,
  output logic [4:0] condition,
  output logic [3:0] eventOn,
  output logic [3:0] eventOff,
  output logic [TS_W-1:0] eventTime,
  output logic [20:0] remainingReleaseTime
);

  // ----------------------------------------------------------------
  // types and state
  // ----------------------------------------------------------------
  localparam int REL_W = 21;
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam int REC_W = TS_W + 4 + 3 + REL_W + REL_W;
  localparam logic [3:0] REC_LAST = 4'(`SWFG_REC_DEPTH - 1);
  localparam logic [3:0] REC_FULL = 4'(`SWFG_REC_DEPTH);

  typedef struct packed {
    swfg_pkg::swfg_state_t st;
    logic armPrev;
    logic [TICK_W-1:0] tick;
    logic [REL_W-1:0] elapsed;
    logic forceEn;
    logic [1:0] forceSel;
    logic storeOn;
    logic storeOff;
    logic [NGRP-1:0][REL_W-1:0] relInt;
    logic [3:0][CNT_W-1:0] cnt;
    logic [3:0] flags;
    logic [3:0] evOn;
    logic [3:0] evOff;
    logic [TS_W-1:0] evTime;
    logic actOut;
    logic tripOut;
    logic [4:0] cond;
    logic [REL_W-1:0] remain;
    logic [3:0] recSel;
    logic [3:0] recPtr;
    logic [3:0] recCnt;
    logic [31:0] rdata;
  } swfg_regs_t;

  swfg_regs_t s_q;
  swfg_regs_t s_d;
  logic [1:0] rstSync_q;
  logic rstn;
  logic recWr;
  logic [REC_W-1:0] recWrData;
  logic [REC_W-1:0] recRdData;

  function automatic logic [REL_W-1:0] clampRel(input logic [31:0] v);
    clampRel = (v > 32'(`SWFG_REL_MAX_MS)) ? `SWFG_REL_MAX_MS : v[REL_W-1:0];
  endfunction

  function automatic logic [3:0] wrapInc(input logic [3:0] v);
    wrapInc = (v == REC_LAST) ? 4'h0 : v + 4'h1;
  endfunction

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstn = rstSync_q[1];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [REL_W-1:0] grpInt;
    logic anyFault;
    logic rise;
    logic expired;
    logic tickHit;
    logic [3:0] flagsNew;
    logic [3:0] onEv;
    logic [3:0] offEv;
    swfg_pkg::swfg_state_t effSt;
    int idx;
    grpInt = '0;
    anyFault = 1'b0;
    rise = 1'b0;
    expired = 1'b0;
    tickHit = 1'b0;
    flagsNew = '0;
    onEv = '0;
    offEv = '0;
    effSt = swfg_pkg::ST_NORMAL;
    idx = 0;
    s_d = s_q;
    recWr = 1'b0;

    // register writes
    if (regWr) begin
      if (regAddr == `SWFG_A_CTRL) begin
        s_d.forceEn = regWdata[`SWFG_CTRL_FEN];
        s_d.forceSel = regWdata[`SWFG_CTRL_FSEL_HI:`SWFG_CTRL_FSEL_LO];
        s_d.storeOn = regWdata[`SWFG_CTRL_ON];
        s_d.storeOff = regWdata[`SWFG_CTRL_OFF];
      end
      if (regAddr == `SWFG_A_CNTCLR) begin
        for (int i = 0; i < 4; i++) begin
          if (regWdata[i]) begin
            s_d.cnt[i] = '0;
          end
        end
      end
      if (regAddr >= `SWFG_A_REL0 && regAddr <= `SWFG_A_REL7 && regAddr[1:0] == 2'h0) begin
        idx = int'(regAddr - `SWFG_A_REL0) / 4;
        if (idx < NGRP) begin
          s_d.relInt[idx] = clampRel(regWdata);
        end
      end
      if (regAddr == `SWFG_A_RECSEL) begin
        s_d.recSel = regWdata[3:0];
      end
    end

    // window sequencing
    grpInt = s_d.relInt[settingGroupSelect];
    anyFault = |faultDetectorInput;
    rise = armingInput & ~s_q.armPrev;
    s_d.armPrev = armingInput;
    expired = s_q.elapsed >= grpInt;
    tickHit = s_q.tick == TICK_LAST;
    s_d.tick = tickHit ? '0 : s_q.tick + TICK_W'(1);
    if ((s_q.st == swfg_pkg::ST_ACTIVE || s_q.st == swfg_pkg::ST_TRIP) && tickHit && !expired) begin
      s_d.elapsed = s_q.elapsed + REL_W'(1);
    end
    case (s_q.st)
      swfg_pkg::ST_NORMAL: begin
        if (guardBlockInput) begin
          s_d.st = swfg_pkg::ST_BLOCKED;
        end else if (rise) begin
          s_d.st = swfg_pkg::ST_INIT;
          s_d.elapsed = '0;
          s_d.tick = '0;
        end
      end
      swfg_pkg::ST_BLOCKED: begin
        if (!guardBlockInput) begin
          s_d.st = swfg_pkg::ST_NORMAL;
        end
      end
      swfg_pkg::ST_INIT: begin
        s_d.st = anyFault ? swfg_pkg::ST_TRIP : swfg_pkg::ST_ACTIVE;
      end
      swfg_pkg::ST_ACTIVE: begin
        if (anyFault) begin
          s_d.st = swfg_pkg::ST_TRIP;
        end else if (expired) begin
          s_d.st = swfg_pkg::ST_NORMAL;
        end
      end
      swfg_pkg::ST_TRIP: begin
        if (!anyFault) begin
          s_d.st = expired ? swfg_pkg::ST_NORMAL : swfg_pkg::ST_ACTIVE;
        end
      end
      default: begin
        s_d.st = swfg_pkg::ST_NORMAL;
      end
    endcase

    // forcing overrides what the outside sees
    effSt = s_d.st;
    if (s_d.forceEn) begin
      case (swfg_pkg::swfg_force_t'(s_d.forceSel))
        swfg_pkg::FRC_NORMAL: effSt = swfg_pkg::ST_NORMAL;
        swfg_pkg::FRC_BLOCKED: effSt = swfg_pkg::ST_BLOCKED;
        swfg_pkg::FRC_ACTIVE: effSt = swfg_pkg::ST_ACTIVE;
        swfg_pkg::FRC_TRIP: effSt = swfg_pkg::ST_TRIP;
        default: effSt = s_d.st;
      endcase
    end
    s_d.cond = effSt;

    // condition flags, events and outputs
    flagsNew[`SWFG_EV_INIT] = effSt == swfg_pkg::ST_INIT;
    flagsNew[`SWFG_EV_BLOCK] = effSt == swfg_pkg::ST_BLOCKED;
    flagsNew[`SWFG_EV_ACT] = effSt == swfg_pkg::ST_ACTIVE || effSt == swfg_pkg::ST_TRIP;
    flagsNew[`SWFG_EV_TRIP] = effSt == swfg_pkg::ST_TRIP;
    onEv = flagsNew & ~s_q.flags;
    offEv = ~flagsNew & s_q.flags;
    s_d.flags = flagsNew;
    s_d.evOn = onEv & {4{s_d.storeOn}};
    s_d.evOff = offEv & {4{s_d.storeOff}};
    if (|(onEv | offEv)) begin
      s_d.evTime = timeNow;
    end
    s_d.actOut = flagsNew[`SWFG_EV_ACT];
    s_d.tripOut = flagsNew[`SWFG_EV_TRIP];
    s_d.remain = '0;
    if (flagsNew[`SWFG_EV_ACT] && s_d.elapsed < grpInt) begin
      s_d.remain = grpInt - s_d.elapsed;
    end

    // counters: an occurrence beats a clear in the same cycle
    for (int i = 0; i < 4; i++) begin
      if (onEv[i]) begin
        s_d.cnt[i] = s_d.cnt[i] + CNT_W'(1);
      end
    end

    // activation record
    if (onEv[`SWFG_EV_ACT]) begin
      recWr = 1'b1;
      s_d.recPtr = wrapInc(s_q.recPtr);
      s_d.recCnt = (s_q.recCnt == REC_FULL) ? REC_FULL : s_q.recCnt + 4'h1;
    end
    recWrData = {timeNow, `SWFG_RECID_ACT_ON, settingGroupSelect, s_d.remain, s_d.elapsed};

    // register reads
    s_d.rdata = '0;
    if (regRd) begin
      if (regAddr == `SWFG_A_CTRL) begin
        s_d.rdata = 32'({s_q.storeOff, s_q.storeOn, s_q.forceSel, s_q.forceEn});
      end
      if (regAddr == `SWFG_A_STATUS) begin
        s_d.rdata = 32'({settingGroupSelect, 1'b0, s_q.tripOut, s_q.actOut, s_q.cond});
      end
      if (regAddr == `SWFG_A_REMAIN) begin
        s_d.rdata = 32'(s_q.remain);
      end
      if (regAddr == `SWFG_A_ELAPSED) begin
        s_d.rdata = 32'(s_q.elapsed);
      end
      if (regAddr >= `SWFG_A_CNT0 && regAddr <= `SWFG_A_CNT3 && regAddr[1:0] == 2'h0) begin
        s_d.rdata = 32'(s_q.cnt[regAddr[3:2]]);
      end
      if (regAddr >= `SWFG_A_REL0 && regAddr <= `SWFG_A_REL7 && regAddr[1:0] == 2'h0) begin
        idx = int'(regAddr - `SWFG_A_REL0) / 4;
        s_d.rdata = (idx < NGRP) ? 32'(s_q.relInt[idx]) : '0;
      end
      if (regAddr == `SWFG_A_RECSEL) begin
        s_d.rdata = 32'(s_q.recSel);
      end
      if (regAddr == `SWFG_A_RECINFO) begin
        s_d.rdata = 32'({s_q.recCnt, s_q.recPtr});
      end
      if (regAddr == `SWFG_A_RECTIME) begin
        s_d.rdata = 32'(recRdData[REC_W-1 -: TS_W]);
      end
      if (regAddr == `SWFG_A_RECID) begin
        s_d.rdata = 32'({recRdData[2*REL_W +: 3], 4'h0, recRdData[2*REL_W+3 +: 4]});
      end
      if (regAddr == `SWFG_A_RECREM) begin
        s_d.rdata = 32'(recRdData[REL_W +: REL_W]);
      end
      if (regAddr == `SWFG_A_RECELA) begin
        s_d.rdata = 32'(recRdData[REL_W-1:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.st <= swfg_pkg::ST_NORMAL;
      s_q.cond <= swfg_pkg::ST_NORMAL;
      s_q.relInt <= {NGRP{`SWFG_REL_DEF_MS}};
      s_q.storeOn <= 1'b1;
      s_q.storeOff <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // record log
  // ----------------------------------------------------------------
  swfg_record_mem #(
    .WIDTH(REC_W),
    .DEPTH(`SWFG_REC_DEPTH),
    .ADDR_W(4)
  ) recordMem (
    .clk(clk),
    .wrEn(recWr),
    .wrAddr(s_q.recPtr),
    .wrData(recWrData),
    .rdAddr(s_d.recSel),
    .rdData(recRdData)
  );

  assign regRdata = s_q.rdata;
  assign guardActiveOutput = s_q.actOut;
  assign guardTripOutput = s_q.tripOut;
  assign condition = s_q.cond;
  assign eventOn = s_q.evOn;
  assign eventOff = s_q.evOff;
  assign eventTime = s_q.evTime;
  assign remainingReleaseTime = s_q.remain;

endmodule

`default_nettype wire

// >>> bench/swfg_assertions.sv
// port checker for the switch-onto-fault guard
`timescale 1ns/1ps
`default_nettype none
module swfg_assertions #(
  parameter int NFAULT = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic armingInput,
  input wire logic guardBlockInput,
  input wire logic [NFAULT-1:0] faultDetectorInput,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic guardActiveOutput,
  input wire logic guardTripOutput,
  input wire logic [4:0] condition,
  input wire logic [3:0] eventOn,
  input wire logic [3:0] eventOff,
  input wire logic [20:0] remainingReleaseTime
);
  // ----------------------------------------------------------------
  // control shadow
  // ----------------------------------------------------------------
  logic [4:0] ctrlQ;
  logic frc;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrlQ <= 5'h18;
    end else if (regWr && regAddr == 8'h00) begin
      ctrlQ <= regWdata[4:0];
    end
  end
  assign frc = ctrlQ[0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_arm_init: assert property (
    $rose(armingInput) && condition == 5'h01 && !guardBlockInput && !frc
    |=> condition == 5'h02) else $error("arming edge not taken");
  a_held_no_arm: assert property (
    condition == 5'h01 && armingInput && $past(armingInput) && !frc
    |=> condition != 5'h02) else $error("held level re-armed");
  a_block_enter: assert property (
    guardBlockInput && condition == 5'h01 && !frc
    |=> condition == 5'h10) else $error("block not entered");
  a_block_hold: assert property (
    guardBlockInput && condition == 5'h10 && !frc
    |=> condition == 5'h10) else $error("window started while blocked");
  a_fault_trip: assert property (
    (condition == 5'h02 || condition == 5'h04) && |faultDetectorInput && !frc
    |=> guardTripOutput && condition == 5'h08) else $error("fault did not trip");
  a_trip_release: assert property (
    condition == 5'h08 && faultDetectorInput == '0 && !frc
    |=> !guardTripOutput) else $error("trip stuck");
  a_init_active: assert property (
    condition == 5'h02 && faultDetectorInput == '0 && !frc
    |=> condition == 5'h04 && guardActiveOutput) else $error("init not followed by active");
  a_idle_no_trip: assert property (
    condition == 5'h01 && !frc |=> !guardTripOutput) else $error("trip outside window");
  a_idle_remain: assert property (
    condition == 5'h01 && !frc |-> remainingReleaseTime == 21'h0)
    else $error("remaining time not zero");
  a_init_event: assert property (
    $rose(condition[1]) && ctrlQ[3] |-> eventOn[0]) else $error("init on event missing");
  a_active_off: assert property (
    $fell(guardActiveOutput) && ctrlQ[4] |-> eventOff[2])
    else $error("active off event missing");
  a_rdata_idle: assert property (
    !regRd |=> regRdata == 32'h0) else $error("read data outside read slot");
endmodule
`default_nettype wire

// >>> bench/swfg_far_side.sv
// far-side model: breaker close, protection starts and user logic
`timescale 1ns/1ps
`default_nettype none
module swfg_far_side (
  input wire logic clk,
  input wire logic cmdArm,
  input wire logic cmdBlock,
  input wire logic [3:0] cmdFault,
  input wire logic [2:0] cmdGroup,
  output logic armingInput,
  output logic guardBlockInput,
  output logic [3:0] faultDetectorInput,
  output logic [2:0] settingGroupSelect,
  output logic [31:0] timeNow
);
  // levels launched just after the edge, system time free running
  initial begin
    armingInput = 1'b0;
    guardBlockInput = 1'b0;
    faultDetectorInput = 4'h0;
    settingGroupSelect = 3'h0;
    timeNow = 32'h0;
  end
  always @(posedge clk) begin
    armingInput <= cmdArm;
    guardBlockInput <= cmdBlock;
    faultDetectorInput <= cmdFault;
    settingGroupSelect <= cmdGroup;
    timeNow <= timeNow + 32'h1;
  end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// testbench for the switch-onto-fault guard
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int TK = 10;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cmdArm = 1'b0;
  logic cmdBlock = 1'b0;
  logic [3:0] cmdFault = 4'h0;
  logic [2:0] cmdGroup = 3'h0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic armingInput, guardBlockInput, guardActiveOutput, guardTripOutput;
  logic [3:0] faultDetectorInput, eventOn, eventOff;
  logic [2:0] settingGroupSelect;
  logic [31:0] timeNow, regRdata, eventTime;
  logic [4:0] condition;
  logic [20:0] remainingReleaseTime;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int nAct = 0;
  always #5 clk = ~clk;
  swfg_far_side u_far (.clk, .cmdArm, .cmdBlock, .cmdFault, .cmdGroup, .armingInput,
    .guardBlockInput, .faultDetectorInput, .settingGroupSelect, .timeNow);
  swfg_switch_onto_fault_guard #(.TICK_CYCLES(TK)) u_dut (.clk, .resetn, .armingInput,
    .guardBlockInput, .faultDetectorInput, .settingGroupSelect, .timeNow, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .guardActiveOutput, .guardTripOutput,
    .condition, .eventOn, .eventOff, .eventTime, .remainingReleaseTime);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(nm, regRdata, e);
  endtask
  task automatic waitc(input logic [4:0] st, input int n);
    int k;
    k = 0;
    while (condition !== st && k < n) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("condition", 32'(condition), 32'(st));
  endtask
  task automatic arm;
    @(posedge clk);
    cmdArm <= 1'b1;
    @(posedge clk);
    cmdArm <= 1'b0;
    #1;
  endtask
  task automatic recchk(input logic [31:0] id, input logic [31:0] rem);
    logic [31:0] n;
    n = (nAct > 12) ? 32'd12 : 32'(nAct);
    rchk(8'h64, (n << 4) | 32'(nAct % 12), "recinfo");
    wr(8'h60, 32'((nAct + 11) % 12));
    rchk(8'h74, id, "recid");
    rchk(8'h78, rem, "recrem");
    rchk(8'h7c, 32'h0, "recela");
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rchk(8'h00, 32'h18, "ctrl");
    rchk(8'h04, 32'h1, "status");
    for (int g = 0; g < 8; g++) begin
      rchk(8'h40 + 8'(4 * g), 32'h3e8, "relint");
    end
    wr(8'h44, 32'h00ffffff);
    rchk(8'h44, 32'h1b7740, "relmax");
    rchk(8'h1c, 32'h0, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_window;
    int k;
    wr(8'h40, 32'h5);
    @(posedge clk);
    cmdArm <= 1'b1;
    waitc(5'h02, 6);
    chk("initOn", 32'(eventOn), 32'h1);
    chk("evTime", eventTime, timeNow - 32'h1);
    @(posedge clk);
    #1;
    chk("actOn", 32'({eventOn, eventOff, guardActiveOutput}), 32'h83);
    chk("remain", 32'(remainingReleaseTime), 32'h5);
    k = 0;
    while (condition === 5'h04 && k < 200) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("winlen", 32'(k >= 4 * TK && k <= 6 * TK), 32'h1);
    nAct++;
    cmdFault <= 4'h1;
    repeat (10) @(posedge clk);
    #1;
    chk("heldarm", 32'({condition, guardTripOutput}), 32'h2);
    cmdArm <= 1'b0;
    cmdFault <= 4'h0;
    $display("test window done");
  endtask
  task automatic t_trip;
    wr(8'h08, 32'hf);
    wr(8'h44, 32'h3);
    cmdGroup <= 3'h1;
    for (int i = 0; i < 4; i++) begin
      arm();
      waitc(5'h04, 6);
      cmdFault <= 4'(1 << i);
      waitc(5'h08, 5);
      chk("trip", 32'({eventOn, guardTripOutput, guardActiveOutput}), 32'h23);
      cmdFault <= 4'h0;
      waitc(5'h04, 5);
      waitc(5'h01, 60);
      nAct++;
    end
    rchk(8'h20, 32'h4, "cntInit");
    rchk(8'h28, 32'h4, "cntAct");
    rchk(8'h2c, 32'h4, "cntTrip");
    recchk(32'h104, 32'h3);
    $display("test trip done");
  endtask
  task automatic t_block;
    wr(8'h08, 32'hf);
    rchk(8'h2c, 32'h0, "cntClr");
    cmdBlock <= 1'b1;
    waitc(5'h10, 5);
    arm();
    repeat (5) @(posedge clk);
    #1;
    chk("blocked", 32'(condition), 32'h10);
    cmdBlock <= 1'b0;
    waitc(5'h01, 5);
    rchk(8'h24, 32'h1, "cntBlock");
    rchk(8'h20, 32'h0, "cntInitB");
    $display("test block done");
  endtask
  task automatic t_group;
    wr(8'h40, 32'h14);
    cmdGroup <= 3'h0;
    arm();
    waitc(5'h04, 6);
    repeat (40) @(posedge clk);
    #1;
    chk("grp0", 32'(condition), 32'h4);
    rchk(8'h10, 32'h4, "elapsed");
    rchk(8'h0c, 32'h10, "remainReg");
    cmdGroup <= 3'h1;
    waitc(5'h01, 8);
    nAct++;
    $display("test group done");
  endtask
  task automatic t_mask;
    logic [3:0] onSeen;
    logic [3:0] offSeen;
    onSeen = 4'h0;
    offSeen = 4'h0;
    wr(8'h00, 32'h10);
    wr(8'h48, 32'h0);
    cmdGroup <= 3'h2;
    arm();
    repeat (8) begin
      @(posedge clk);
      #1;
      onSeen = onSeen | eventOn;
      offSeen = offSeen | eventOff;
    end
    chk("maskOn", 32'(onSeen), 32'h0);
    chk("maskOff", 32'(offSeen), 32'h5);
    nAct++;
    wr(8'h00, 32'h18);
    $display("test mask done");
  endtask
  task automatic t_records;
    logic [3:0] onSeen;
    logic [3:0] offSeen;
    onSeen = 4'h0;
    offSeen = 4'h0;
    wr(8'h00, 32'h08);
    repeat (13) begin
      arm();
      repeat (4) begin
        @(posedge clk);
        #1;
        onSeen = onSeen | eventOn;
        offSeen = offSeen | eventOff;
      end
      nAct++;
    end
    chk("maskOnOnly", 32'(onSeen), 32'h5);
    chk("maskNoOff", 32'(offSeen), 32'h0);
    wr(8'h00, 32'h18);
    recchk(32'h204, 32'h0);
    $display("test records done");
  endtask
  task automatic t_force;
    logic [4:0] st [4] = '{5'h01, 5'h10, 5'h04, 5'h08};
    for (int s = 0; s < 4; s++) begin
      wr(8'h00, 32'h19 | 32'(s << 1));
      repeat (3) @(posedge clk);
      #1;
      chk("force", 32'(condition), 32'(st[s]));
      chk("forceOut", 32'({guardActiveOutput, guardTripOutput}), 32'({s > 1, s == 3}));
    end
    wr(8'h00, 32'h18);
    waitc(5'h01, 5);
    $display("test force done");
  endtask
  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_window();
    t_trip();
    t_block();
    t_group();
    t_mask();
    t_records();
    t_force();
    results();
  end
endmodule
bind swfg_switch_onto_fault_guard swfg_assertions #(.NFAULT(NFAULT)) u_chk (.clk, .resetn,
  .armingInput, .guardBlockInput, .faultDetectorInput, .regAddr, .regWdata, .regWr, .regRd,
  .regRdata, .guardActiveOutput, .guardTripOutput, .condition, .eventOn, .eventOff,
  .remainingReleaseTime);
`default_nettype wire
